// file: verilog/timebase_map.svh
`ifndef TIMEBASE_MAP_SVH
`define TIMEBASE_MAP_SVH

// ==========================================================
// Register byte offsets (32-bit aligned words)
`define R_CFG1 9'h000
`define R_CFG2 9'h004
`define R_CFG3 9'h008
`define R_ICFG 9'h00C
`define R_IEN  9'h010
`define R_IFLG 9'h014
`define R_PRIO 9'h018
`define R_HSVC 9'h01C
`define R_SCHS 9'h020
// Address bit that selects the parameter storage window.
`define R_PAR_BIT 8

// ==========================================================
// Field positions
`define F1_B1PS 1:0
`define F1_B2PS 3:2
`define F1_EMUL 4
`define F1_GATE 5
`define F1_STDV 6
`define F1_EDGE 7
`define F3_EPE  0
`define F3_EDF  5:1
`define F3_PD   6
`define FI_LINE 2:0
`define FI_SLOT 4:3

// ==========================================================
// Reset values
`define CFG1_RST 8'hC0
`define CFG2_RST 1'h0
`define CFG3_RST 7'h00
`define ICFG_RST 5'h00

// ==========================================================
// Prescaler terminal counts
`define STD_LIM_SLOW 6'h1F
`define STD_LIM_FAST 6'h03
`define EIGHTH_LAST  3'h7

`endif

// file: verilog/timebase_pkg.sv
package timebase_pkg;

	// Service priority code of one channel.
	typedef enum logic [1:0] {
		PRI_OFF  = 2'b00,
		PRI_LOW  = 2'b01,
		PRI_MID  = 2'b10,
		PRI_HIGH = 2'b11
	} prio_t;

	// Scheduler: waiting for a request or engine busy.
	typedef enum logic {
		SCH_IDLE = 1'b0,
		SCH_BUSY = 1'b1
	} sched_state_t;

	// Commands from the microengine.
	typedef struct packed {
		logic [3:0]  chan;
		logic        match_wr;
		logic        match_tb;
		logic        capt_tb;
		logic [15:0] match_val;
		logic        link_wr;
		logic [3:0]  link_chan;
		logic        flag_set;
		logic        done;
	} eng_cmd_t;

	// Engine access to one parameter pair.
	typedef struct packed {
		logic        wr;
		logic [5:0]  addr;
		logic [31:0] data;
	} eng_par_t;

	// Service grant to the microengine.
	typedef struct packed {
		logic       valid;
		logic [3:0] chan;
	} grant_t;

endpackage : timebase_pkg

// file: verilog/timebase_sched.sv
`timescale 1ns/1ps
`include "timebase_map.svh"
// Overview of operation
// (R1) Two 16-bit time bases; each channel's match and capture references one.
// (R2) Match or capture event raises a channel service request to the scheduler.
// (R3) Per-channel comparators detect events every clock, independent of channel count.
// (R4) All channels identical; engine may address any channel by number.
// (R5) A channel may post link requests to other channels without the CPU.
// (R6) Three priority levels; ties at one level resolved by channel number.
// (R7) Same-level pending requests served in channel order before repeating one.
// (R8) Parameter pairs of two 16-bit words are read and written as one word.
// (R9) Emulation enable routes microcode fetch to emulation RAM and blocks bus access.
// (R10) Emulation link: 9-bit address, 32-bit data, same timing as the ROM.
// (R11) Per-channel flag set by functions; requests interrupt only when enabled.
// (R12) Drives programmed request level onto eight active-low request lines.
// (R13) Slot select picks one of four time slots; no priority among sources.
// (R14) Standard prescaler divides bus clock by 32 or by 4.
// (R15) Enhanced prescaler divides by twice the field plus two.
// (R16) First base further divided by 1, 2, 4 or 8.
// (R17) Half-rate override makes the first base count at clock over two.
// (R18) Second base clock: rise, gated, fall, or both edges of the pin.
// (R19) Gate mode: pin high lets the eighth-rate tick count; low holds.
// (R20) External pin is synchronised and filtered before edge detection.
// (R21) External edges must be at least nine bus clocks apart.
// (R22) Second prescaler 1,2,4,8; with pre-divide 1,3,7,15 external, 8..120 internal.
// (R23) Time bases visible to the engine only, never on the register bus.
// (R24) Time bases wrap to zero and clear on reset.
module timebase_sched
	import timebase_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [8:0]  bus_addr,
	input  wire logic [31:0] bus_wdata,
	input  wire logic        bus_we,
	input  wire logic        bus_re,
	output logic      [31:0] bus_rdata,
	input  wire logic        ext_timebase_pin,
	input  wire logic [15:0] chan_pin,
	input  wire eng_cmd_t    eng_cmd,
	input  wire eng_par_t    eng_par,
	output logic      [31:0] eng_par_rdata,
	output grant_t           grant,
	output logic      [15:0] chan_capture,
	output logic      [15:0] time_base_one,
	output logic      [15:0] time_base_two,
	input  wire logic [8:0]  ucode_addr,
	input  wire logic        ucode_rd,
	input  wire logic [31:0] rom_data,
	input  wire logic [31:0] emul_data,
	output logic      [8:0]  emul_addr,
	output logic             emul_rd,
	output logic      [31:0] ucode_data,
	output logic             emul_bus_block,
	input  wire logic [1:0]  slot_now,
	output logic      [7:0]  irq_n
);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// ==========================================================
	// Register bus decode
	logic [7:0]  cfg1;
	logic        cfg2;
	logic [6:0]  cfg3;
	logic [4:0]  icfg;
	logic [15:0] ien;
	logic [15:0] iflg;
	logic [31:0] prio_r;
	logic [31:0] par [64];
	logic [31:0] next_rdata;
	logic [15:0] pend;
	sched_state_t st;

	wire       par_hit  = bus_addr[`R_PAR_BIT];
	wire [5:0] par_idx  = bus_addr[7:2];
	wire       cfg_wr   = bus_we && !par_hit;
	wire       wr_cfg1  = cfg_wr && bus_addr == `R_CFG1;
	wire       wr_cfg2  = cfg_wr && bus_addr == `R_CFG2;
	wire       wr_cfg3  = cfg_wr && bus_addr == `R_CFG3;
	wire       wr_icfg  = cfg_wr && bus_addr == `R_ICFG;
	wire       wr_ien   = cfg_wr && bus_addr == `R_IEN;
	wire       wr_iflg  = cfg_wr && bus_addr == `R_IFLG;
	wire       wr_prio  = cfg_wr && bus_addr == `R_PRIO;
	wire       wr_hsvc  = cfg_wr && bus_addr == `R_HSVC;

	// Field views of the configuration words.
	wire [1:0] b1ps   = cfg1[`F1_B1PS];
	wire [1:0] b2ps   = cfg1[`F1_B2PS];
	wire       emul_en = cfg1[`F1_EMUL];
	wire       gate    = cfg1[`F1_GATE];
	wire       std_div = cfg1[`F1_STDV];
	wire       edge2  = cfg1[`F1_EDGE];
	wire       epe    = cfg3[`F3_EPE];
	wire [4:0] edf    = cfg3[`F3_EDF];
	wire       pd     = cfg3[`F3_PD];

	// Software-written configuration; time bases are never mapped here.
	always_ff @(posedge ref_clk) begin // see (R23)
		if (rst) begin
			cfg1   <= `CFG1_RST;
			cfg2   <= `CFG2_RST;
			cfg3   <= `CFG3_RST;
			icfg   <= `ICFG_RST;
			ien    <= '0;
			prio_r <= '0;
		end else begin
			if (wr_cfg1) cfg1 <= bus_wdata[7:0];
			if (wr_cfg2) cfg2 <= bus_wdata[0];
			if (wr_cfg3) cfg3 <= bus_wdata[6:0];
			if (wr_icfg) icfg <= bus_wdata[4:0];
			if (wr_ien) ien <= bus_wdata[15:0];
			if (wr_prio) prio_r <= bus_wdata;
		end
	end

	// Read mux; unmapped offsets read as zero, data only after a read strobe.
	always_comb begin
		next_rdata = '0;
		if (bus_re && par_hit) begin
			next_rdata = par[par_idx]; // see (R8)
		end else if (bus_re) begin
			case (bus_addr)
				`R_CFG1: next_rdata = {24'h00_0000, cfg1};
				`R_CFG2: next_rdata = {31'h0000_0000, cfg2};
				`R_CFG3: next_rdata = {25'h000_0000, cfg3};
				`R_ICFG: next_rdata = {27'h000_0000, icfg};
				`R_IEN:  next_rdata = {16'h0000, ien};
				`R_IFLG: next_rdata = {16'h0000, iflg};
				`R_PRIO: next_rdata = prio_r;
				`R_HSVC: next_rdata = {16'h0000, pend};
				`R_SCHS: next_rdata = {27'h000_0000, st, grant.chan};
				default: next_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) bus_rdata <= '0;
		else bus_rdata <= next_rdata;
	end

	// ==========================================================
	// First time base prescaler
	logic [5:0] pre_cnt;
	logic [2:0] p1_cnt;
	logic       half;

	// Enhanced limit 2f+1 gives a period of 2f+2 clocks.
	wire [5:0] pre_lim  = epe ? {edf, 1'b1} : // see (R15)
		(std_div ? `STD_LIM_FAST : `STD_LIM_SLOW); // see (R14)
	// A compare with >= recovers if the limit shrinks mid-count.
	wire       pre_tick = pre_cnt >= pre_lim;
	wire [2:0] p1_mask  = {b1ps == 2'h3, b1ps[1], |b1ps};
	wire       chain1   = pre_tick && (p1_cnt & p1_mask) == p1_mask; // see (R16)
	wire       tick1    = cfg2 ? half : chain1; // see (R17)

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pre_cnt       <= '0;
			p1_cnt        <= '0;
			half          <= 1'b0;
			time_base_one <= '0;
		end else begin
			pre_cnt       <= pre_tick ? 6'h00 : pre_cnt + 6'h01;
			p1_cnt        <= p1_cnt + 3'(pre_tick);
			half          <= ~half;
			time_base_one <= time_base_one + 16'(tick1); // see (R1) (R24)
		end
	end

	// ==========================================================
	// Second time base: pin conditioning and prescaler
	logic       pin_s1;
	logic       pin_s2;
	logic       pin_s3;
	logic       filt;
	logic       filt_d;
	logic [2:0] d8_cnt;
	logic [3:0] p2_cnt;

	// Pin edge spacing is not checked here; the source must keep edges nine clocks apart.
	wire       d8_tick = d8_cnt == `EIGHTH_LAST; // see (R21)
	wire       rise    = filt && !filt_d;
	wire       fall    = !filt && filt_d;
	wire       src2    = gate ? (edge2 ? (rise || fall) : (d8_tick && filt)) // see (R18) (R19)
		: (edge2 ? fall : rise);
	// Limit is N-1, or 2N-2 with the pre-divide bit.
	wire [2:0] nm1     = {b2ps == 2'h3, b2ps[1], |b2ps};
	wire [3:0] p2_lim  = pd ? {nm1, 1'b0} : {1'b0, nm1}; // see (R22)
	wire       tick2   = src2 && p2_cnt >= p2_lim;

	// Filter needs two equal synchronised samples, so glitches do not count.
	always_ff @(posedge ref_clk) begin // see (R20)
		if (rst) begin
			{pin_s1, pin_s2, pin_s3, filt, filt_d} <= '0;
		end else begin
			pin_s1 <= ext_timebase_pin;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			if (pin_s2 == pin_s3) filt <= pin_s3;
			filt_d <= filt;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			d8_cnt        <= '0;
			p2_cnt        <= '0;
			time_base_two <= '0;
		end else begin
			d8_cnt        <= d8_cnt + 3'h1;
			if (src2) p2_cnt <= tick2 ? 4'h0 : p2_cnt + 4'h1;
			time_base_two <= time_base_two + 16'(tick2); // see (R1) (R24)
		end
	end

	// ==========================================================
	// Channel event hardware, one identical slice per channel
	logic [15:0] mreg [16];
	logic [15:0] capt [16];
	logic [15:0] armed;
	logic [15:0] mtb;
	logic [15:0] ctb;
	logic [15:0] pin_d;
	wire  [15:0] match_ev;
	wire  [15:0] capt_ev;
	wire  [15:0] wr_m;
	wire  [15:0] link_ev;
	wire  [15:0] flag_ev;
	wire  [15:0] req_hi;
	wire  [15:0] req_md;
	wire  [15:0] req_lo;
	logic [3:0]  gsel;
	wire         gnt_fire;

	for (genvar i = 0; i < 16; i++) begin : g_ch
		wire        sel  = eng_cmd.chan == 4'(i); // see (R4)
		// Half-range difference gives greater-or-equal across wrap.
		wire [15:0] diff = (mtb[i] ? time_base_two : time_base_one) - mreg[i];
		assign match_ev[i] = armed[i] && !diff[15]; // see (R3)
		assign capt_ev[i]  = chan_pin[i] && !pin_d[i];
		assign wr_m[i]     = eng_cmd.match_wr && sel;
		assign link_ev[i]  = eng_cmd.link_wr && eng_cmd.link_chan == 4'(i); // see (R5)
		assign flag_ev[i]  = eng_cmd.flag_set && sel;
		assign req_hi[i]   = pend[i] && prio_r[2*i+:2] == PRI_HIGH; // see (R6)
		assign req_md[i]   = pend[i] && prio_r[2*i+:2] == PRI_MID;
		assign req_lo[i]   = pend[i] && prio_r[2*i+:2] == PRI_LOW;

		capt_req_a: assert property (capt_ev[i] |=> pend[i]) // see (R2)
			else $error("capture event did not raise a request");
	end

	// Events and host writes set pending; a new event beats a grant clear.
	wire [15:0] host_ev = wr_hsvc ? bus_wdata[15:0] : 16'h0000;
	wire [15:0] svc_ev  = match_ev | capt_ev | link_ev | host_ev; // see (R2)
	wire [15:0] gnt_clr = gnt_fire ? 16'h0001 << gsel : 16'h0000;
	wire [15:0] flg_clr = wr_iflg ? bus_wdata[15:0] : 16'h0000;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			{armed, mtb, ctb, pin_d, pend, iflg} <= '0;
			for (int k = 0; k < 16; k++) begin
				mreg[k] <= '0;
				capt[k] <= '0;
			end
		end else begin
			pin_d <= chan_pin;
			armed <= (armed & ~match_ev) | wr_m;
			pend  <= (pend & ~gnt_clr) | svc_ev;
			iflg  <= (iflg & ~flg_clr) | flag_ev; // see (R11)
			for (int k = 0; k < 16; k++) begin
				if (wr_m[k]) begin
					mreg[k] <= eng_cmd.match_val;
					mtb[k]  <= eng_cmd.match_tb;
					ctb[k]  <= eng_cmd.capt_tb;
				end
				if (capt_ev[k]) capt[k] <= ctb[k] ? time_base_two : time_base_one;
			end
		end
	end

	// ==========================================================
	// Scheduler with a round-robin pointer per level
	logic [3:0] ptr_hi;
	logic [3:0] ptr_md;
	logic [3:0] ptr_lo;

	// First requesting channel at or after the start index, wrapping.
	function automatic logic [3:0] pick(input logic [15:0] req, input logic [3:0] start);
		logic [3:0] idx;
		pick = start;
		for (int k = 15; k >= 0; k--) begin
			idx = start + 4'(k);
			if (req[idx]) pick = idx;
		end
	endfunction : pick

	wire any_hi = |req_hi;
	wire any_md = |req_md;
	wire any_lo = |req_lo;
	assign gnt_fire = st == SCH_IDLE && (any_hi || any_md || any_lo);

	always_comb begin
		if (any_hi) gsel = pick(req_hi, ptr_hi);
		else if (any_md) gsel = pick(req_md, ptr_md);
		else gsel = pick(req_lo, ptr_lo);
	end

	// Pointer moves past the served channel, so others go first next time.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st <= SCH_IDLE;
			grant <= '0;
			{ptr_hi, ptr_md, ptr_lo} <= '0;
			chan_capture <= '0;
		end else begin
			grant.valid <= gnt_fire;
			if (gnt_fire) begin
				grant.chan   <= gsel;
				chan_capture <= capt[gsel];
				if (any_hi) ptr_hi <= gsel + 4'h1; // see (R7)
				else if (any_md) ptr_md <= gsel + 4'h1; // see (R7)
				else ptr_lo <= gsel + 4'h1; // see (R7)
			end
			unique case (st)
				SCH_IDLE: if (gnt_fire) st <= SCH_BUSY;
				SCH_BUSY: if (eng_cmd.done) st <= SCH_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Parameter storage, one 32-bit word per pair; engine write wins
	always_ff @(posedge ref_clk) begin // see (R8)
		if (rst) begin
			eng_par_rdata <= '0;
			for (int k = 0; k < 64; k++) par[k] <= '0;
		end else begin
			if (bus_we && par_hit) par[par_idx] <= bus_wdata;
			if (eng_par.wr) par[eng_par.addr] <= eng_par.data;
			eng_par_rdata <= par[eng_par.addr];
		end
	end

	// ==========================================================
	// Control store redirection and interrupt request lines
	logic       irq_act;
	logic [4:0] irq_cfg;

	// One register stage on both sources keeps fetch timing identical.
	assign emul_addr      = emul_en ? ucode_addr : 9'h000; // see (R10)
	assign emul_rd        = emul_en && ucode_rd;
	assign emul_bus_block = emul_en; // see (R9)
	// Sources sharing a level are simply ORed; software sorts them out.
	assign irq_n = (irq_act && slot_now == irq_cfg[`FI_SLOT]) // see (R13)
		? ~(8'h01 << irq_cfg[`FI_LINE]) : 8'hFF; // see (R12)

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ucode_data <= '0;
			irq_act    <= 1'b0;
			irq_cfg    <= '0;
		end else begin
			ucode_data <= emul_en ? emul_data : rom_data; // see (R9)
			irq_act    <= |(iflg & ien); // see (R11)
			irq_cfg    <= icfg;
		end
	end

	// ==========================================================
	// Checks
	base1_wrap_a: assert property (tick1 |=> time_base_one == $past(time_base_one) + 16'h0001) // see (R24)
		else $error("first time base did not step by one");
	std_div_a: assert property (@(posedge ref_clk) disable iff (rst || cfg_wr) // see (R14)
		!cfg_wr && pre_tick && !epe && std_div |=> !pre_tick [*3] ##1 pre_tick)
		else $error("fast standard prescaler not divide by four");
	enh_div_a: assert property (@(posedge ref_clk) disable iff (rst || cfg_wr) // see (R15)
		!cfg_wr && pre_tick && epe && edf == 5'h00 |=> !pre_tick ##1 pre_tick)
		else $error("enhanced prescaler code zero not divide by two");
	half_rate_a: assert property (@(posedge ref_clk) disable iff (rst || cfg_wr) // see (R17)
		!cfg_wr && tick1 && cfg2 |=> !tick1 ##1 tick1)
		else $error("half-rate override not every second clock");
	gate_hold_a: assert property (gate && !edge2 && !filt |=> $stable(time_base_two)) // see (R19)
		else $error("second base moved with gate low");
	sched_pri_a: assert property (gnt_fire && any_hi |-> req_hi[gsel]) // see (R6)
		else $error("grant bypassed a high priority request");
	irq_gate_a: assert property ((iflg & ien) == 16'h0000 |=> irq_n == 8'hFF) // see (R11)
		else $error("interrupt driven without an enabled flag");
	irq_slot_a: assert property (slot_now != irq_cfg[`FI_SLOT] |-> irq_n == 8'hFF) // see (R13)
		else $error("interrupt driven in the wrong slot");
	emul_block_a: assert property (!emul_en |-> !emul_rd && !emul_bus_block) // see (R9)
		else $error("emulation path active while disabled");
	pair_rd_a: assert property (bus_we && par_hit && !eng_par.wr // see (R8)
		##1 bus_re && bus_addr == $past(bus_addr) && !eng_par.wr
		|=> bus_rdata == $past(bus_wdata, 2))
		else $error("parameter pair not returned whole");

	grant_c: cover property (gnt_fire ##1 grant.valid);
	irq_c: cover property (irq_n != 8'hFF);
	match_c: cover property (|match_ev);
	gate_c: cover property (gate && !edge2 && tick2);

endmodule : timebase_sched

// file: sim/host_cpu_model.sv
`timescale 1ns/1ps
// ==========================================
// Host side of the register bus
// ==========================================
module host_cpu_model (
	input  wire logic        ref_clk,
	input  wire logic [31:0] bus_rdata,
	output logic      [8:0]  bus_addr,
	output logic      [31:0] bus_wdata,
	output logic             bus_we,
	output logic             bus_re
);
	// The bus starts idle.
	initial begin
		bus_addr  = 9'h000;
		bus_wdata = 32'h0000_0000;
		bus_we    = 1'b0;
		bus_re    = 1'b0;
	end

	// A parameter pair always goes in one 32-bit access, never two halves.
	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		bus_addr  <= a;
		bus_wdata <= d;
		bus_we    <= 1'b1;
		@(posedge ref_clk);
		bus_we    <= 1'b0;
		bus_addr  <= ~a;
		bus_wdata <= ~d;
	endtask : wr

	// Address is scrambled after the strobe so stale values cannot pass for a hold.
	task automatic rd(input logic [8:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		bus_addr <= a;
		bus_re   <= 1'b1;
		@(posedge ref_clk);
		bus_re   <= 1'b0;
		bus_addr <= ~a;
		#1;
		d = bus_rdata;
	endtask : rd

	// Write and read back with no gap, so the pair is seen whole both ways.
	task automatic wr_rd(input logic [8:0] a, input logic [31:0] dw, output logic [31:0] dr);
		@(posedge ref_clk);
		bus_addr  <= a;
		bus_wdata <= dw;
		bus_we    <= 1'b1;
		@(posedge ref_clk);
		bus_we    <= 1'b0;
		bus_re    <= 1'b1;
		@(posedge ref_clk);
		bus_re    <= 1'b0;
		bus_addr  <= ~a;
		bus_wdata <= ~dw;
		#1;
		dr = bus_rdata;
	endtask : wr_rd
endmodule : host_cpu_model

// file: sim/timer_coprocessor_timebase_sched_tb_top.sv
`timescale 1ns/1ps
`include "timebase_map.svh"
module timer_coprocessor_timebase_sched_tb_top;
	import timebase_pkg::*;
	typedef struct packed {
		logic [7:0] cfg1;
		logic       cfg2;
		logic [6:0] cfg3;
		logic       sel;
		logic [7:0] period;
	} row_t;

	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        ext_timebase_pin = 1'b1;
	logic [15:0] chan_pin = 16'h0000;
	eng_cmd_t    cmd = '0;
	eng_par_t    par = '0;
	logic [8:0]  ucode_addr = 9'h1A5;
	logic        ucode_rd = 1'b1;
	logic [31:0] rom_data = 32'h1111_2222;
	logic [31:0] emul_data = 32'h3333_4444;
	logic [1:0]  slot_now = 2'h0;
	logic [8:0]  bus_addr;
	logic [31:0] bus_wdata;
	logic        bus_we;
	logic        bus_re;
	logic [31:0] bus_rdata;
	logic [31:0] eng_par_rdata;
	grant_t      grant;
	logic [15:0] chan_capture;
	logic [15:0] time_base_one;
	logic [15:0] time_base_two;
	logic [8:0]  emul_addr;
	logic        emul_rd;
	logic [31:0] ucode_data;
	logic        emul_bus_block;
	logic [7:0]  irq_n;
	logic [31:0] d;
	logic [15:0] v;
	int          n_mismatch = 0;
	int          checks_done = 0;
	int          hits;

	// Rows: config words, base under test, steps between increments.
	row_t rows [12] = '{
		'{8'h00, 1'b0, 7'h00, 1'b0, 8'h20}, '{8'h40, 1'b0, 7'h00, 1'b0, 8'h04},
		'{8'h43, 1'b0, 7'h00, 1'b0, 8'h20}, '{8'h01, 1'b0, 7'h00, 1'b0, 8'h40},
		'{8'h00, 1'b0, 7'h01, 1'b0, 8'h02}, '{8'h00, 1'b0, 7'h3F, 1'b0, 8'h40},
		'{8'h02, 1'b0, 7'h07, 1'b0, 8'h20}, '{8'h03, 1'b1, 7'h00, 1'b0, 8'h02},
		'{8'h20, 1'b0, 7'h00, 1'b1, 8'h08}, '{8'h24, 1'b0, 7'h40, 1'b1, 8'h18},
		'{8'h2C, 1'b0, 7'h40, 1'b1, 8'h78}, '{8'h28, 1'b0, 7'h00, 1'b1, 8'h20}};
	logic [7:0] ed_cfg [3] = '{8'h00, 8'h80, 8'hA0};
	logic [7:0] ed_exp [3] = '{8'h04, 8'h04, 8'h08};

	// ==========================================
	// Clock, partner and device
	// ==========================================
	always #25 ref_clk = ~ref_clk;

	host_cpu_model u_host (
		.ref_clk   (ref_clk),
		.bus_rdata (bus_rdata),
		.bus_addr  (bus_addr),
		.bus_wdata (bus_wdata),
		.bus_we    (bus_we),
		.bus_re    (bus_re)
	);

	timebase_sched u_dut (
		.ref_clk          (ref_clk),
		.rst              (rst),
		.bus_addr         (bus_addr),
		.bus_wdata        (bus_wdata),
		.bus_we           (bus_we),
		.bus_re           (bus_re),
		.bus_rdata        (bus_rdata),
		.ext_timebase_pin (ext_timebase_pin),
		.chan_pin         (chan_pin),
		.eng_cmd          (cmd),
		.eng_par          (par),
		.eng_par_rdata    (eng_par_rdata),
		.grant            (grant),
		.chan_capture     (chan_capture),
		.time_base_one    (time_base_one),
		.time_base_two    (time_base_two),
		.ucode_addr       (ucode_addr),
		.ucode_rd         (ucode_rd),
		.rom_data         (rom_data),
		.emul_data        (emul_data),
		.emul_addr        (emul_addr),
		.emul_rd          (emul_rd),
		.ucode_data       (ucode_data),
		.emul_bus_block   (emul_bus_block),
		.slot_now         (slot_now),
		.irq_n            (irq_n)
	);

	// ==========================================
	// Helpers
	// ==========================================
	task automatic tally_and_finish;
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish

	task automatic giveup;
		n_mismatch++;
		tally_and_finish();
	endtask : giveup

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// The first two intervals after a change of setting are discarded.
	task automatic meas(input logic sel, input logic [7:0] exp);
		logic [15:0] prev;
		int          n;
		n = 0;
		for (int k = 0; k < 3; k++) begin
			n = 0;
			prev = sel ? time_base_two : time_base_one;
			while ((sel ? time_base_two : time_base_one) === prev) begin
				@(posedge ref_clk);
				#1;
				n++;
				if (n > 600) giveup();
			end
		end
		chk(n, {24'h0, exp});
	endtask : meas

	task automatic grant_is(input logic [3:0] c);
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
			if (n > 60) giveup();
		end while (grant.valid !== 1'b1);
		chk({28'h0, grant.chan}, {28'h0, c});
	endtask : grant_is

	task automatic svc_done;
		@(posedge ref_clk);
		cmd.done <= 1'b1;
		@(posedge ref_clk);
		cmd.done <= 1'b0;
	endtask : svc_done

	// ==========================================
	// Main sequence
	// ==========================================
	initial begin
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		// Rate table; config three readback guards the field widths.
		for (int i = 0; i < 12; i++) begin
			u_host.wr(`R_CFG1, {24'h0, rows[i].cfg1});
			u_host.wr(`R_CFG2, {31'h0, rows[i].cfg2});
			u_host.wr(`R_CFG3, {25'h0, rows[i].cfg3});
			u_host.rd(`R_CFG3, d);
			chk(d, {25'h0, rows[i].cfg3});
			meas(rows[i].sel, rows[i].period);
		end
		// A low gate pin freezes base two.
		@(posedge ref_clk);
		ext_timebase_pin <= 1'b0;
		repeat (20) @(posedge ref_clk);
		#1;
		v = time_base_two;
		repeat (100) @(posedge ref_clk);
		#1;
		chk({16'h0, time_base_two}, {16'h0, v});
		// Pin edges ten clocks apart, counted per edge mode.
		for (int m = 0; m < 3; m++) begin
			u_host.wr(`R_CFG1, {24'h0, ed_cfg[m]});
			repeat (20) @(posedge ref_clk);
			#1;
			v = time_base_two;
			repeat (4) begin
				repeat (10) @(posedge ref_clk);
				ext_timebase_pin <= 1'b1;
				repeat (10) @(posedge ref_clk);
				ext_timebase_pin <= 1'b0;
			end
			repeat (12) @(posedge ref_clk);
			#1;
			chk({16'h0, 16'(time_base_two - v)}, {24'h0, ed_exp[m]});
		end
		// Emulation routing, off then on.
		#1;
		chk({21'h0, emul_bus_block, emul_rd, emul_addr}, 32'h0000_0000);
		chk(ucode_data, 32'h1111_2222);
		u_host.wr(`R_CFG1, 32'h0000_0010);
		repeat (2) @(posedge ref_clk);
		#1;
		chk({21'h0, emul_bus_block, emul_rd, emul_addr}, 32'h0000_07A5);
		chk(ucode_data, 32'h3333_4444);
		// Scheduler: fast base one, mixed priorities.
		u_host.wr(`R_CFG1, 32'h0000_0000);
		u_host.wr(`R_CFG3, 32'h0000_0001);
		u_host.wr(`R_PRIO, 32'h030C_4C60);
		@(posedge ref_clk);
		chan_pin <= 16'h1225;
		#1;
		v = time_base_one;
		grant_is(4'h5);
		chk({16'h0, chan_capture}, {16'h0, v});
		@(posedge ref_clk);
		chan_pin <= 16'h0000;
		repeat (2) @(posedge ref_clk);
		chan_pin <= 16'h0020;
		svc_done();
		grant_is(4'h9);
		svc_done();
		grant_is(4'hC);
		svc_done();
		grant_is(4'h5);
		svc_done();
		grant_is(4'h2);
		svc_done();
		chan_pin <= 16'h0000;
		hits = 0;
		repeat (40) begin
			@(posedge ref_clk);
			#1;
			if (grant.valid !== 1'b0) hits++;
		end
		chk(hits, 32'h0000_0000);
		// Channel zero has no priority, so its capture stays pending unserved.
		u_host.rd(`R_HSVC, d);
		chk(d, 32'h0000_0001);
		u_host.rd(`R_SCHS, d);
		chk(d, 32'h0000_0002);
		// Match on channel three against base one.
		@(posedge ref_clk);
		cmd.chan      <= 4'h3;
		cmd.match_tb  <= 1'b0;
		cmd.match_val <= time_base_one + 16'h0010;
		cmd.match_wr  <= 1'b1;
		@(posedge ref_clk);
		cmd.match_wr  <= 1'b0;
		grant_is(4'h3);
		svc_done();
		// Link request from the engine, then a host request.
		@(posedge ref_clk);
		cmd.link_chan <= 4'h7;
		cmd.link_wr   <= 1'b1;
		@(posedge ref_clk);
		cmd.link_wr   <= 1'b0;
		grant_is(4'h7);
		svc_done();
		u_host.wr(`R_HSVC, 32'h0000_0004);
		grant_is(4'h2);
		svc_done();
		// Interrupt on line five, slot two, channel four.
		u_host.wr(`R_ICFG, 32'h0000_0015);
		u_host.wr(`R_IEN, 32'h0000_0010);
		@(posedge ref_clk);
		cmd.chan     <= 4'h4;
		cmd.flag_set <= 1'b1;
		slot_now     <= 2'h1;
		@(posedge ref_clk);
		cmd.flag_set <= 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
		chk({24'h0, irq_n}, 32'h0000_00FF);
		@(posedge ref_clk);
		slot_now <= 2'h2;
		@(posedge ref_clk);
		#1;
		chk({24'h0, irq_n}, 32'h0000_00DF);
		u_host.wr(`R_IEN, 32'h0000_0000);
		repeat (3) @(posedge ref_clk);
		#1;
		chk({24'h0, irq_n}, 32'h0000_00FF);
		u_host.rd(`R_IFLG, d);
		chk(d, 32'h0000_0010);
		u_host.wr(`R_IFLG, 32'h0000_0010);
		u_host.rd(`R_IFLG, d);
		chk(d, 32'h0000_0000);
		// Parameter pairs cross both ways whole; an unmapped place reads zero.
		u_host.wr_rd(9'h104, 32'hCAFE_1234, d);
		chk(d, 32'hCAFE_1234);
		@(posedge ref_clk);
		par.addr <= 6'h01;
		@(posedge ref_clk);
		#1;
		chk(eng_par_rdata, 32'hCAFE_1234);
		@(posedge ref_clk);
		par.wr   <= 1'b1;
		par.addr <= 6'h02;
		par.data <= 32'h5A5A_0F0F;
		@(posedge ref_clk);
		par.wr   <= 1'b0;
		u_host.rd(9'h108, d);
		chk(d, 32'h5A5A_0F0F);
		u_host.wr(9'h040, 32'hFFFF_FFFF);
		u_host.rd(9'h040, d);
		chk(d, 32'h0000_0000);
		// Mid-run reset clears both bases and restores config one.
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
		chk({time_base_one, time_base_two}, 32'h0000_0000);
		@(posedge ref_clk);
		rst <= 1'b0;
		u_host.rd(`R_CFG1, d);
		chk(d, 32'h0000_00C0);
		tally_and_finish();
	end
endmodule : timer_coprocessor_timebase_sched_tb_top
